// ===== logic/eal_addsub.v
// Eight-bit adder and subtractor with carry, half-carry and overflow
`timescale 1ns/10ps
`include "eal_defines.vh"
module eal_addsub (
   // Operands
   input  wire [7:0] a_i,
   input  wire [7:0] b_i,
   input  wire       cin_i,
   input  wire       sub_i,
   // Results
   output wire [7:0] sum_o,
   output wire       cout_o,
   output wire       half_o,
   output wire       ovf_o
);
   wire [7:0] b_eff;
   wire       c_eff;
   wire [8:0] full;
   wire [4:0] nib;

   // Subtract as a + ~b + ~borrow; carries invert back into borrows
   assign b_eff  = sub_i ? ~b_i : b_i;
   assign c_eff  = sub_i ? ~cin_i : cin_i;
   assign full   = {1'b0, a_i} + {1'b0, b_eff} + {8'h00, c_eff};
   assign nib    = {1'b0, a_i[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, c_eff};
   assign sum_o  = full[7:0];
   assign cout_o = full[8] ^ sub_i;
   assign half_o = nib[`EAL_NIB_W] ^ sub_i;
   assign ovf_o  = (a_i[`EAL_SIGN_BIT] == b_eff[`EAL_SIGN_BIT]) &&
                   (full[`EAL_SIGN_BIT] != a_i[`EAL_SIGN_BIT]);
endmodule // eal_addsub

// ===== logic/eal_defines.vh
// Constants for the eight-bit arithmetic and logic unit
`ifndef EAL_DEFINES_VH
`define EAL_DEFINES_VH

// Register byte offsets on the APB
`define EAL_OFF_CTRL   8'h00
`define EAL_OFF_DST    8'h04
`define EAL_OFF_DSTH   8'h08
`define EAL_OFF_SRC    8'h0c
`define EAL_OFF_FLAGS  8'h10
`define EAL_OFF_STATUS 8'h14

// Reset values
`define EAL_RST_BYTE   8'h00
`define EAL_RST_OP     5'h00
`define EAL_RST_WORD   32'h0000_0000

// Flag bit positions in the flag register
`define EAL_F_C        0
`define EAL_F_Z        1
`define EAL_F_N        2
`define EAL_F_V        3
`define EAL_F_S        4
`define EAL_F_H        5

// Status register bit positions
`define EAL_ST_BUSY    0

// Operation codes
`define EAL_OP_ADD     5'h01
`define EAL_OP_ADC     5'h02
`define EAL_OP_WADD    5'h03
`define EAL_OP_SUB     5'h04
`define EAL_OP_SUBK    5'h05
`define EAL_OP_SBC     5'h06
`define EAL_OP_SBCK    5'h07
`define EAL_OP_WSUB    5'h08
`define EAL_OP_AND     5'h09
`define EAL_OP_ANDK    5'h0a
`define EAL_OP_OR      5'h0b
`define EAL_OP_ORK     5'h0c
`define EAL_OP_EOR     5'h0d
`define EAL_OP_BSET    5'h0e
`define EAL_OP_BCLR    5'h0f
`define EAL_OP_TEST    5'h10

// Sizes
`define EAL_OP_W       5
`define EAL_SIGN_BIT   7
`define EAL_NIB_W      4

`endif

// ===== logic/eal_top.v
// Eight-bit arithmetic and logic unit with an APB register file
//
// Contract
// - Register add, optional carry, five flags, one clock
// - Word add immediate on pair, two clocks
// - Subtract register or constant, five flags, one clock
// - Subtract operand and carry, five flags, one clock
// - Word subtract immediate on pair, two clocks
// - AND with register or constant, Z N V
// - OR and exclusive OR, Z N V, one clock
// - Masked bit set ORs mask into destination
// - Test ANDs register with itself, no write
//
// The implementer's own choices: the APB slave port and the address map.
`timescale 1ns/10ps
`include "eal_defines.vh"
module eal_top (
   // Clock, reset, enable
   input  wire        CLK_SYS_I,
   input  wire        RST_N_I,
   input  wire        CE_I,
   // APB slave
   input  wire        PSEL_I,
   input  wire        PENABLE_I,
   input  wire        PWRITE_I,
   input  wire [7:0]  PADDR_I,
   input  wire [31:0] PWDATA_I,
   output reg  [31:0] PRDATA_O,
   output reg         PREADY_O,
   output reg         PSLVERR_O,
   // Status
   output reg  [7:0]  FLAGS_O,
   output reg         BUSY_O
);
   localparam [1:0] ST_IDLE  = 2'b00;
   localparam [1:0] ST_EXEC  = 2'b01;
   localparam [1:0] ST_WORD2 = 2'b10;

   reg  [1:0]              state_q;
   reg  [`EAL_OP_W-1:0]    op_q;
   reg  [7:0]              dst_q;
   reg  [7:0]              dsth_q;
   reg  [7:0]              src_q;
   reg                     wcarry_q;
   reg                     wzero_q;
   reg  [31:0]             rd_d;
   reg                     hit_d;
   reg  [7:0]              as_a;
   reg  [7:0]              as_b;
   reg                     as_cin;
   reg                     as_sub;
   reg  [7:0]              logic_res;
   reg                     is_arith;
   reg                     is_word;
   reg                     is_logic;
   reg                     use_carry;
   reg                     valid_op;
   reg                     writes_dst;

   wire [7:0]              as_sum;
   wire                    as_cout;
   wire                    as_half;
   wire                    as_ovf;
   wire                    acc_done;
   wire                    wr_done;

   assign acc_done = PSEL_I & PENABLE_I & PREADY_O;
   assign wr_done  = acc_done & PWRITE_I & hit_d;

   // Operation decode
   always @* begin
      is_arith   = 1'b0;
      is_word    = 1'b0;
      is_logic   = 1'b0;
      use_carry  = 1'b0;
      as_sub     = 1'b0;
      writes_dst = 1'b1;
      logic_res  = dst_q;
      case (op_q)
         `EAL_OP_ADD: begin
            is_arith = 1'b1;
         end
         `EAL_OP_ADC: begin
            is_arith  = 1'b1;
            use_carry = 1'b1;
         end
         `EAL_OP_WADD: begin
            is_word = 1'b1;
         end
         `EAL_OP_SUB, `EAL_OP_SUBK: begin
            is_arith = 1'b1;
            as_sub   = 1'b1;
         end
         `EAL_OP_SBC, `EAL_OP_SBCK: begin
            is_arith  = 1'b1;
            as_sub    = 1'b1;
            use_carry = 1'b1;
         end
         `EAL_OP_WSUB: begin
            is_word = 1'b1;
            as_sub  = 1'b1;
         end
         `EAL_OP_AND, `EAL_OP_ANDK: begin
            is_logic  = 1'b1;
            logic_res = dst_q & src_q;
         end
         `EAL_OP_OR, `EAL_OP_ORK: begin
            is_logic  = 1'b1;
            logic_res = dst_q | src_q;
         end
         `EAL_OP_EOR: begin
            is_logic  = 1'b1;
            logic_res = dst_q ^ src_q;
         end
         `EAL_OP_BSET: begin
            is_logic  = 1'b1;
            logic_res = dst_q | src_q;
         end
         `EAL_OP_BCLR: begin
            is_logic  = 1'b1;
            logic_res = dst_q & ~src_q;
         end
         `EAL_OP_TEST: begin
            is_logic   = 1'b1;
            writes_dst = 1'b0;
            logic_res  = dst_q & dst_q;
         end
         default: begin
            writes_dst = 1'b0;
         end
      endcase
   end

   // Adder operand select: low byte first, then high byte with carry
   always @* begin
      if (state_q == ST_WORD2) begin
         as_a   = dsth_q;
         as_b   = `EAL_RST_BYTE;
         as_cin = wcarry_q;
      end else begin
         as_a   = dst_q;
         as_b   = src_q;
         as_cin = use_carry & FLAGS_O[`EAL_F_C];
      end
   end

   eal_addsub u_addsub (
      .a_i    (as_a),
      .b_i    (as_b),
      .cin_i  (as_cin),
      .sub_i  (as_sub),
      .sum_o  (as_sum),
      .cout_o (as_cout),
      .half_o (as_half),
      .ovf_o  (as_ovf)
   );

   // Opcode legality for control writes
   always @* begin
      case (PWDATA_I[`EAL_OP_W-1:0])
         `EAL_OP_ADD, `EAL_OP_ADC, `EAL_OP_WADD, `EAL_OP_SUB,
         `EAL_OP_SUBK, `EAL_OP_SBC, `EAL_OP_SBCK, `EAL_OP_WSUB,
         `EAL_OP_AND, `EAL_OP_ANDK, `EAL_OP_OR, `EAL_OP_ORK,
         `EAL_OP_EOR, `EAL_OP_BSET, `EAL_OP_BCLR, `EAL_OP_TEST:
            valid_op = 1'b1;
         default:
            valid_op = 1'b0;
      endcase
   end

   // Read mux and address decode
   always @* begin
      rd_d  = `EAL_RST_WORD;
      hit_d = 1'b1;
      case (PADDR_I)
         `EAL_OFF_CTRL:   rd_d[`EAL_OP_W-1:0] = op_q;
         `EAL_OFF_DST:    rd_d[7:0] = dst_q;
         `EAL_OFF_DSTH:   rd_d[7:0] = dsth_q;
         `EAL_OFF_SRC:    rd_d[7:0] = src_q;
         `EAL_OFF_FLAGS:  rd_d[7:0] = FLAGS_O;
         `EAL_OFF_STATUS: rd_d[`EAL_ST_BUSY] = BUSY_O;
         default:         hit_d = 1'b0;
      endcase
   end

   // Bus answer: one wait state, held off while an operation runs
   always @(posedge CLK_SYS_I) begin
      if (!RST_N_I) begin
         PREADY_O  <= 1'b0;
         PSLVERR_O <= 1'b0;
         PRDATA_O  <= `EAL_RST_WORD;
      end else if (CE_I) begin
         if (PSEL_I && PENABLE_I && !PREADY_O && state_q == ST_IDLE) begin
            PREADY_O  <= 1'b1;
            PSLVERR_O <= ~hit_d;
            PRDATA_O  <= PWRITE_I ? `EAL_RST_WORD : rd_d;
         end else begin
            PREADY_O  <= 1'b0;
            PSLVERR_O <= 1'b0;
         end
      end
   end

   // Registers, sequencing and flag update
   always @(posedge CLK_SYS_I) begin
      if (!RST_N_I) begin
         state_q  <= ST_IDLE;
         op_q     <= `EAL_RST_OP;
         dst_q    <= `EAL_RST_BYTE;
         dsth_q   <= `EAL_RST_BYTE;
         src_q    <= `EAL_RST_BYTE;
         FLAGS_O  <= `EAL_RST_BYTE;
         BUSY_O   <= 1'b0;
         wcarry_q <= 1'b0;
         wzero_q  <= 1'b0;
      end else if (CE_I) begin
         case (state_q)
            ST_IDLE: begin
               if (wr_done) begin
                  case (PADDR_I)
                     `EAL_OFF_CTRL: begin
                        if (valid_op) begin
                           op_q    <= PWDATA_I[`EAL_OP_W-1:0];
                           state_q <= ST_EXEC;
                           BUSY_O  <= 1'b1;
                        end
                     end
                     `EAL_OFF_DST:   dst_q   <= PWDATA_I[7:0];
                     `EAL_OFF_DSTH:  dsth_q  <= PWDATA_I[7:0];
                     `EAL_OFF_SRC:   src_q   <= PWDATA_I[7:0];
                     `EAL_OFF_FLAGS: FLAGS_O <= PWDATA_I[7:0];
                     default: begin
                     end
                  endcase
               end
            end
            ST_EXEC: begin
               if (is_word) begin
                  dst_q    <= as_sum;
                  wcarry_q <= as_cout;
                  wzero_q  <= (as_sum == `EAL_RST_BYTE);
                  state_q  <= ST_WORD2;
               end else begin
                  if (is_arith) begin
                     // S is not touched by byte arithmetic
                     if (writes_dst)
                        dst_q <= as_sum;
                     FLAGS_O[`EAL_F_C] <= as_cout;
                     FLAGS_O[`EAL_F_Z] <= (as_sum == `EAL_RST_BYTE);
                     FLAGS_O[`EAL_F_N] <= as_sum[`EAL_SIGN_BIT];
                     FLAGS_O[`EAL_F_V] <= as_ovf;
                     FLAGS_O[`EAL_F_H] <= as_half;
                  end else if (is_logic) begin
                     // C, S and H keep their values
                     if (writes_dst)
                        dst_q <= logic_res;
                     FLAGS_O[`EAL_F_Z] <= (logic_res == `EAL_RST_BYTE);
                     FLAGS_O[`EAL_F_N] <= logic_res[`EAL_SIGN_BIT];
                     FLAGS_O[`EAL_F_V] <= 1'b0;
                  end
                  state_q <= ST_IDLE;
                  BUSY_O  <= 1'b0;
               end
            end
            ST_WORD2: begin
               // H is not touched by word operations
               dsth_q            <= as_sum;
               FLAGS_O[`EAL_F_C] <= as_cout;
               FLAGS_O[`EAL_F_Z] <= wzero_q & (as_sum == `EAL_RST_BYTE);
               FLAGS_O[`EAL_F_N] <= as_sum[`EAL_SIGN_BIT];
               FLAGS_O[`EAL_F_V] <= as_ovf;
               FLAGS_O[`EAL_F_S] <= as_sum[`EAL_SIGN_BIT] ^ as_ovf;
               state_q           <= ST_IDLE;
               BUSY_O            <= 1'b0;
            end
            default: begin
               state_q <= ST_IDLE;
               BUSY_O  <= 1'b0;
            end
         endcase
      end
   end
endmodule // eal_top

// ===== verif/eal_chk_props.sv
// Checker for bus answer, busy and flag timing of the unit
`timescale 1ns/10ps
module eal_chk (
   // Clock, reset, enable
   input wire        CLK_SYS_I,
   input wire        RST_N_I,
   input wire        CE_I,
   // Bus
   input wire        PSEL_I,
   input wire        PENABLE_I,
   input wire        PWRITE_I,
   input wire [7:0]  PADDR_I,
   input wire [31:0] PWDATA_I,
   input wire [31:0] PRDATA_O,
   input wire        PREADY_O,
   input wire        PSLVERR_O,
   // Status
   input wire [7:0]  FLAGS_O,
   input wire        BUSY_O
);
   wire       tk = PSEL_I & PENABLE_I & PREADY_O & PWRITE_I;
   wire [4:0] op = PWDATA_I[4:0];
   wire       op_go = tk && PADDR_I == 8'h00 && !BUSY_O;
   default clocking cb @(posedge CLK_SYS_I); endclocking
   // A low enable freezes everything, so timing checks pause with it
   default disable iff (!RST_N_I || !CE_I);
   a_ready_pulse: assert property (
      PREADY_O |=> !PREADY_O) else $error("ready too long");
   a_ready_access: assert property (
      PREADY_O |-> PSEL_I && PENABLE_I) else $error("ready outside");
   a_idle_answer: assert property (
      PSEL_I && !PENABLE_I ##1 PENABLE_I |-> ##[1:4] PREADY_O)
      else $error("no answer");
   a_busy_start: assert property (
      tk && PADDR_I == 8'h00 && op != 5'h00 && op <= 5'h10 |=> BUSY_O)
      else $error("op not started");
   a_busy_len: assert property (
      $rose(BUSY_O) |-> ##[1:2] !BUSY_O) else $error("op too long");
   a_illegal_op: assert property (
      tk && PADDR_I == 8'h00 && op > 5'h10 && !BUSY_O |=> !BUSY_O)
      else $error("illegal op ran");
   a_flags_hold: assert property (
      !BUSY_O && !(tk && PADDR_I == 8'h10) |=> $stable(FLAGS_O))
      else $error("flags moved");
   a_flags_write: assert property (
      tk && PADDR_I == 8'h10 |=> FLAGS_O == $past(PWDATA_I[7:0]))
      else $error("flags not written");
   a_err_map: assert property (
      PREADY_O && PADDR_I[1:0] == 2'b00 |-> PSLVERR_O == (PADDR_I > 8'h14))
      else $error("wrong error answer");
   a_rd_upper: assert property (
      PREADY_O && !PWRITE_I |-> PRDATA_O[31:8] == 24'h0)
      else $error("upper read bits set");
   a_logic_carry: assert property (
      op_go && op >= 5'h09 && op <= 5'h10 |-> ##2
      FLAGS_O[0] == $past(FLAGS_O[0], 2) && !FLAGS_O[3])
      else $error("logic op moved carry or kept overflow");
   a_byte_sign: assert property (
      op_go && op >= 5'h01 && op <= 5'h07 && op != 5'h03 |-> ##2
      FLAGS_O[4] == $past(FLAGS_O[4], 2))
      else $error("byte op moved sign flag");
   a_word_half: assert property (
      op_go && (op == 5'h03 || op == 5'h08) |-> ##3
      FLAGS_O[5] == $past(FLAGS_O[5], 3) &&
      FLAGS_O[4] == (FLAGS_O[2] ^ FLAGS_O[3]))
      else $error("word op flags wrong");
   c_word: cover property (tk && PADDR_I == 8'h00 && op == 5'h03);
   c_freeze: cover property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
      !CE_I && BUSY_O);
   c_stall: cover property (PSEL_I && PENABLE_I && BUSY_O);
   c_err: cover property (PSLVERR_O);
endmodule // eal_chk
bind eal_top eal_chk u_chk (.CLK_SYS_I(CLK_SYS_I), .RST_N_I(RST_N_I),
   .CE_I(CE_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
   .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I),
   .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
   .FLAGS_O(FLAGS_O), .BUSY_O(BUSY_O));

// ===== verif/eal_mst.sv
// Bus master model standing in for the core decoder side
`timescale 1ns/10ps
module eal_mst (
   // Clock and answer
   input  wire        clk_i,
   input  wire        pready_i,
   input  wire        pslverr_i,
   input  wire [31:0] prdata_i,
   // Request
   output reg         psel_o,
   output reg         penable_o,
   output reg         pwrite_o,
   output reg  [7:0]  paddr_o,
   output reg  [31:0] pwdata_o
);
   initial begin
      psel_o = 1'b0;
      penable_o = 1'b0;
      pwrite_o = 1'b0;
      paddr_o = 8'h00;
      pwdata_o = 32'h0;
   end
   // Request held until ready is sampled, then lines scrambled
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic e, output logic t);
      int n;
      begin
         n = 0;
         @(posedge clk_i);
         psel_o <= 1'b1;
         pwrite_o <= w;
         paddr_o <= a;
         pwdata_o <= d;
         @(posedge clk_i);
         penable_o <= 1'b1;
         @(posedge clk_i);
         while (pready_i !== 1'b1 && n < 40) begin
            @(posedge clk_i);
            n = n + 1;
         end
         q = prdata_i;
         e = pslverr_i;
         t = pready_i !== 1'b1;
         psel_o <= 1'b0;
         penable_o <= 1'b0;
         paddr_o <= ~a;
         pwdata_o <= ~d;
      end
   endtask
endmodule // eal_mst

// ===== verif/testbench.sv
// Self-checking bench for the arithmetic and logic unit
`timescale 1ns/10ps
`include "eal_defines.vh"
module testbench;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        ce = 1'b1;
   wire         sel, en, wr, rdy, err, busy;
   wire [7:0]   adr, flg;
   wire [31:0]  wd, rd;
   logic [31:0] q;
   logic        e, t;
   logic [7:0]  d, h, s, f;
   logic [4:0]  op;
   logic [23:0] x;
   int          n_errors = 0;
   int          cmp_count = 0;
   initial forever #20 clk = ~clk;
   eal_top dut (.CLK_SYS_I(clk), .RST_N_I(rst_n), .CE_I(ce),
      .PSEL_I(sel), .PENABLE_I(en), .PWRITE_I(wr), .PADDR_I(adr),
      .PWDATA_I(wd), .PRDATA_O(rd), .PREADY_O(rdy),
      .PSLVERR_O(err), .FLAGS_O(flg), .BUSY_O(busy));
   eal_mst mst (.clk_i(clk), .pready_i(rdy), .pslverr_i(err),
      .prdata_i(rd), .psel_o(sel), .penable_o(en), .pwrite_o(wr),
      .paddr_o(adr), .pwdata_o(wd));
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      begin
         cmp_count++;
         if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: %h vs %h", $time, seen, exp);
         end
      end
   endtask
   task give_verdict;
      begin
         $display("%0d compares, %0d mismatches", cmp_count, n_errors);
         if (n_errors == 0 && cmp_count > 0)
            $display("TB: PASS");
         else
            $display("TB: FAIL");
         $finish;
      end
   endtask
   task bus(input logic w, input logic [7:0] a, input logic [31:0] v);
      begin
         mst.xfer(w, a, v, q, e, t);
         if (t) begin
            n_errors++;
            give_verdict;
         end
      end
   endtask
   // Reference: {high byte, low byte, flags}
   function automatic logic [23:0] mdl(input logic [4:0] o,
      input logic [7:0] d, h, s, f);
      int r, w, c;
      logic v;
      logic [7:0] g;
      g = f;
      if (o == 3 || o == 8) begin
         w = {h, d};
         r = o == 3 ? w + s : w - s;
         v = o == 3 ? !w[15] && r[15] : w[15] && !r[15];
         g[0] = o == 3 ? r[16] : r < 0;
         g[3] = v;
         g[4] = r[15] ^ v;
         g[1] = r[15:0] == 0;
         g[2] = r[15];
         return {r[15:8], r[7:0], g};
      end
      if (o < 8) begin
         c = (o == 2 || o > 5) ? f[0] : 0;
         r = o < 3 ? d + s + c : d - s - c;
         g[0] = o < 3 ? r[8] : r < 0;
         g[5] = o < 3 ? d % 16 + s % 16 + c > 15 : d % 16 < s % 16 + c;
         g[3] = (o < 3) == (d[7] == s[7]) && r[7] != d[7];
      end else begin
         case (o)
            9, 10:      r = d & s;
            11, 12, 14: r = d | s;
            13:         r = d ^ s;
            15:         r = d & ~s;
            default:    r = d;
         endcase
         g[3] = 1'b0;
      end
      g[1] = r[7:0] == 0;
      g[2] = r[7];
      return {h, o == 16 ? d : r[7:0], g};
   endfunction
   initial begin
      void'($urandom(32'h15e12601));
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      for (int a = 0; a < 24; a += 4) begin
         bus(1'b0, a[7:0], 32'h0);
         chk(q, 32'h0);
      end
      bus(1'b0, 8'h40, 32'h0);
      chk({e, q[30:0]}, 32'h80000000);
      $display("test reset and decode done");
      for (int i = 0; i < 96; i++) begin
         {d, h, s, f} = $urandom;
         if (i < 16)
            {d, h, s} = 24'hff7f01;
         op = 5'(i % 16 + 1);
         x = mdl(op, d, h, s, f);
         bus(1'b1, `EAL_OFF_DST, {24'h0, d});
         bus(1'b1, `EAL_OFF_DSTH, {24'h0, h});
         bus(1'b1, `EAL_OFF_SRC, {24'h0, s});
         bus(1'b1, `EAL_OFF_FLAGS, {24'h0, f});
         bus(1'b1, `EAL_OFF_CTRL, {27'h0, op});
         bus(1'b0, `EAL_OFF_DST, 32'h0);
         chk(q, x[15:8]);
         bus(1'b0, `EAL_OFF_DSTH, 32'h0);
         chk(q, x[23:16]);
         chk(flg, x[7:0]);
      end
      $display("test operations done");
      bus(1'b1, `EAL_OFF_CTRL, 32'h11);
      bus(1'b0, `EAL_OFF_DST, 32'h0);
      chk(q, x[15:8]);
      chk(flg, x[7:0]);
      $display("test illegal code done");
      // Enable dropped right after the start: busy and flags must freeze
      {d, s, f} = 24'($urandom);
      x = mdl(`EAL_OP_ADC, d, h, s, f);
      bus(1'b1, `EAL_OFF_DST, {24'h0, d});
      bus(1'b1, `EAL_OFF_SRC, {24'h0, s});
      bus(1'b1, `EAL_OFF_FLAGS, {24'h0, f});
      bus(1'b1, `EAL_OFF_CTRL, {27'h0, `EAL_OP_ADC});
      ce <= 1'b0;
      repeat (4) @(posedge clk);
      chk({busy, flg}, {1'b1, f});
      ce <= 1'b1;
      bus(1'b0, `EAL_OFF_DST, 32'h0);
      chk(q, x[15:8]);
      chk(flg, x[7:0]);
      $display("test clock enable done");
      give_verdict;
   end
endmodule // testbench
